/* File: rtl/fip_defs.svh */
// Purpose: Offsets, field positions, reset values and vector figures of the priority block.
// Assumes: Eight-bit special function register space, byte-wide data.
// Notes:   Included by the top module and by the bench.
`ifndef FIP_DEFS_SVH
`define FIP_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define FIP_ADDR_IRQ_ENABLE 8'hA8
`define FIP_ADDR_PRIO_HIGH 8'hB7
`define FIP_ADDR_PRIO_LOW 8'hB8

// ---------------------------------------------------------------
// Field positions and masks
// ---------------------------------------------------------------
`define FIP_GATE_BIT 7
`define FIP_IE_WRITE_MASK 8'hBF
`define FIP_PRIO_WRITE_MASK 8'h3F
`define FIP_RESET_BYTE 8'h00

// ---------------------------------------------------------------
// Source indices, also polling order and enable bit positions
// ---------------------------------------------------------------
`define FIP_SRC_EXT0 3'h0
`define FIP_SRC_TIMER0 3'h1
`define FIP_SRC_EXT1 3'h2
`define FIP_SRC_TIMER1 3'h3
`define FIP_SRC_SERIAL 3'h4
`define FIP_SRC_TIMER2 3'h5

// ---------------------------------------------------------------
// Vector layout: base plus eight bytes per source index
// ---------------------------------------------------------------
`define FIP_VEC_BASE 8'h03
`define FIP_VEC_SHIFT 3

`endif

/* File: rtl/fip_pkg.sv */
// Purpose: Types shared by the priority block modules.
// Assumes: Four priority levels.
// Notes:   Numbers live in fip_defs.svh.
package fip_pkg;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef logic [1:0] fip_level_t;
  typedef logic [2:0] fip_src_t;
  typedef enum logic [0:0] {ST_IDLE, ST_OFFER} fip_state_t;

endpackage

/* File: rtl/fip_level_stack.sv */
// Purpose: Tracks which priority levels are in service, as a nesting stack.
// Assumes: Each push has a level above every level already in service.
// Notes:   Because levels only nest upward, one bit per level is a full stack.
module fip_level_stack import fip_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire fip_level_t push_level,
  input wire logic pop,
  output logic [3:0] in_service,
  output logic any,
  output fip_level_t top_level
);

  logic [3:0] next_in_service;

  // Highest set bit is the routine now running.
  function automatic fip_level_t top_of(input logic [3:0] s);
    fip_level_t t;
    t = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (s[l]) begin
        t = 2'(l);
      end
    end
    return t;
  endfunction

  assign any = |in_service;
  assign top_level = top_of(in_service);

  // A return ends the innermost routine first, then a new entry is recorded.
  always_comb begin
    next_in_service = in_service;
    if (pop && any) begin
      next_in_service[top_level] = 1'b0;
    end
    if (push) begin
      next_in_service[push_level] = 1'b1;
    end
  end

  // Register stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_service <= 4'h0;
    end else begin
      in_service <= next_in_service;
    end
  end

endmodule

/* File: rtl/fip_source_pick.sv */
// Purpose: Picks the pending source to offer next.
// Assumes: Pending bits are already gated by the enables.
// Notes:   Purely combinational; the top module registers its choice.
module fip_source_pick import fip_pkg::*; #(
  parameter int NUM_SRC = 6
) (
  input wire logic [NUM_SRC-1:0] pending,
  input wire logic [NUM_SRC-1:0] prio_high,
  input wire logic [NUM_SRC-1:0] prio_low,
  input wire logic [3:0] in_service,
  output logic found,
  output fip_src_t idx,
  output fip_level_t level
);

  // True when a routine of this level or above is already running.
  function automatic logic blocked(input logic [3:0] s, input int l);
    logic b;
    b = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (k >= l && s[k]) begin
        b = 1'b1;
      end
    end
    return b;
  endfunction

  // Later writes win: highest level last, lowest index last within a level.
  always_comb begin
    found = 1'b0;
    idx = 3'h0;
    level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (pending[i] && {prio_high[i], prio_low[i]} == 2'(l) && !blocked(in_service, l)) begin
          found = 1'b1;
          idx = 3'(i);
          level = 2'(l);
        end
      end
    end
  end

endmodule

/* File: rtl/fip_intc.sv */
// Purpose: Six-source, four-level nested interrupt priority logic.
// Assumes: Request flags and core strobes are synchronous to CLK_SYS.
// Notes:   The core takes an offered vector with INT_ACK and ends it with INT_RETURN.
`include "fip_defs.svh"

// Behaviour
// - Six request sources are arbitrated using four priority levels.
// - Level is high bit then low bit; 00 lowest, 11 highest.
// - A request is offered only above every level now in service.
// - Requests at or below the running level wait until it returns.
// - Higher level preempts; nesting stack resumes the lower routine after return.
// - Vectors 03H to 2BH by source; same-level ties go in that order.
// - Clear edge external flags and timer 0/1 flags on vectoring only.
// - Enable register at 0A8H: gate bit 7, bit 6 zero, enables 5..0.
// - High priority bit register lives at address B7H.
module fip_intc import fip_pkg::*; #(
  parameter int NUM_SRC = 6
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic EXT0_REQUEST_FLAG,
  input wire logic EXT1_REQUEST_FLAG,
  input wire logic EXT0_EDGE_MODE,
  input wire logic EXT1_EDGE_MODE,
  input wire logic TIMER0_OVERFLOW_FLAG,
  input wire logic TIMER1_OVERFLOW_FLAG,
  input wire logic TIMER2_OVERFLOW_FLAG,
  input wire logic TIMER2_EXTERNAL_FLAG,
  input wire logic RX_DONE_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic INT_ACK,
  input wire logic INT_RETURN,
  output logic INT_REQ,
  output logic [7:0] INT_VECTOR,
  output logic EXT0_FLAG_CLEAR,
  output logic EXT1_FLAG_CLEAR,
  output logic TIMER0_FLAG_CLEAR,
  output logic TIMER1_FLAG_CLEAR
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  // The register layout has room for exactly six sources.
  if (NUM_SRC != 6) begin : g_bad_num_src
    $error("fip_intc supports exactly six sources");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] interrupt_enable;
  logic [7:0] priority_high_bits;
  logic [7:0] priority_low_bits;
  logic [7:0] next_interrupt_enable;
  logic [7:0] next_priority_high_bits;
  logic [7:0] next_priority_low_bits;
  logic [7:0] next_rdata;
  fip_state_t state;
  fip_state_t next_state;
  fip_src_t chosen_idx;
  fip_src_t next_chosen_idx;
  fip_level_t chosen_level;
  fip_level_t next_chosen_level;
  logic [7:0] next_vector;
  logic next_ext0_clr;
  logic next_ext1_clr;
  logic next_tmr0_clr;
  logic next_tmr1_clr;
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] pending;
  logic global_irq_gate;
  logic pick_found;
  fip_src_t pick_idx;
  fip_level_t pick_level;
  logic push;
  logic [3:0] in_service;
  logic stack_any;
  fip_level_t top_level;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Vector address of a source index.
  function automatic logic [7:0] vec_of(input fip_src_t i);
    return `FIP_VEC_BASE + {2'b00, i, 3'b000};
  endfunction

  // Register read decode; unmapped addresses read zero.
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] ie,
                                          input logic [7:0] hi, input logic [7:0] lo);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `FIP_ADDR_IRQ_ENABLE: d = ie;
      `FIP_ADDR_PRIO_HIGH: d = hi;
      `FIP_ADDR_PRIO_LOW: d = lo;
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  // Writes store through masks, so bit 6 and unused priority bits stay zero.
  always_comb begin
    next_interrupt_enable = interrupt_enable;
    next_priority_high_bits = priority_high_bits;
    next_priority_low_bits = priority_low_bits;
    if (SFR_WR && SFR_ADDR == `FIP_ADDR_IRQ_ENABLE) begin
      next_interrupt_enable = SFR_WDATA & `FIP_IE_WRITE_MASK;
    end
    if (SFR_WR && SFR_ADDR == `FIP_ADDR_PRIO_HIGH) begin
      next_priority_high_bits = SFR_WDATA & `FIP_PRIO_WRITE_MASK;
    end
    if (SFR_WR && SFR_ADDR == `FIP_ADDR_PRIO_LOW) begin
      next_priority_low_bits = SFR_WDATA & `FIP_PRIO_WRITE_MASK;
    end
    next_rdata = sfr_read(SFR_ADDR, interrupt_enable, priority_high_bits, priority_low_bits);
  end

  // Register stage for the register file and read data.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      interrupt_enable <= `FIP_RESET_BYTE;
      priority_high_bits <= `FIP_RESET_BYTE;
      priority_low_bits <= `FIP_RESET_BYTE;
      SFR_RDATA <= 8'h00;
    end else begin
      interrupt_enable <= next_interrupt_enable;
      priority_high_bits <= next_priority_high_bits;
      priority_low_bits <= next_priority_low_bits;
      SFR_RDATA <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Request gathering
  // ---------------------------------------------------------------
  // Serial and timer 2 each merge two flags into one source.
  assign raw_req = {TIMER2_OVERFLOW_FLAG | TIMER2_EXTERNAL_FLAG, RX_DONE_FLAG | TX_DONE_FLAG,
                    TIMER1_OVERFLOW_FLAG, EXT1_REQUEST_FLAG, TIMER0_OVERFLOW_FLAG,
                    EXT0_REQUEST_FLAG};
  assign global_irq_gate = interrupt_enable[`FIP_GATE_BIT];
  assign pending = raw_req & interrupt_enable[NUM_SRC-1:0] & {NUM_SRC{global_irq_gate}};

  fip_source_pick #(
    .NUM_SRC(NUM_SRC)
  ) u_pick (
    .pending(pending),
    .prio_high(priority_high_bits[NUM_SRC-1:0]),
    .prio_low(priority_low_bits[NUM_SRC-1:0]),
    .in_service(in_service),
    .found(pick_found),
    .idx(pick_idx),
    .level(pick_level)
  );

  // ---------------------------------------------------------------
  // Nesting stack
  // ---------------------------------------------------------------
  assign push = (state == ST_OFFER) && INT_ACK;

  fip_level_stack u_stack (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .push(push),
    .push_level(chosen_level),
    .pop(INT_RETURN),
    .in_service(in_service),
    .any(stack_any),
    .top_level(top_level)
  );

  // ---------------------------------------------------------------
  // Offer sequencer
  // ---------------------------------------------------------------
  // The choice is frozen while offered so the vector cannot change under
  // the core mid-fetch; a request that vanishes is withdrawn instead.
  always_comb begin
    next_state = state;
    next_chosen_idx = chosen_idx;
    next_chosen_level = chosen_level;
    next_vector = INT_VECTOR;
    next_ext0_clr = 1'b0;
    next_ext1_clr = 1'b0;
    next_tmr0_clr = 1'b0;
    next_tmr1_clr = 1'b0;
    case (state)
      ST_IDLE: begin
        if (pick_found) begin
          next_state = ST_OFFER;
          next_chosen_idx = pick_idx;
          next_chosen_level = pick_level;
          next_vector = vec_of(pick_idx);
        end
      end
      ST_OFFER: begin
        if (INT_ACK) begin
          next_state = ST_IDLE;
          next_ext0_clr = (chosen_idx == `FIP_SRC_EXT0) && EXT0_EDGE_MODE;
          next_ext1_clr = (chosen_idx == `FIP_SRC_EXT1) && EXT1_EDGE_MODE;
          next_tmr0_clr = (chosen_idx == `FIP_SRC_TIMER0);
          next_tmr1_clr = (chosen_idx == `FIP_SRC_TIMER1);
        end else if (!pending[chosen_idx]) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Register stage; every output here comes straight from a flop.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      chosen_idx <= 3'h0;
      chosen_level <= 2'h0;
      INT_REQ <= 1'b0;
      INT_VECTOR <= `FIP_VEC_BASE;
      EXT0_FLAG_CLEAR <= 1'b0;
      EXT1_FLAG_CLEAR <= 1'b0;
      TIMER0_FLAG_CLEAR <= 1'b0;
      TIMER1_FLAG_CLEAR <= 1'b0;
    end else begin
      state <= next_state;
      chosen_idx <= next_chosen_idx;
      chosen_level <= next_chosen_level;
      INT_REQ <= (next_state == ST_OFFER);
      INT_VECTOR <= next_vector;
      EXT0_FLAG_CLEAR <= next_ext0_clr;
      EXT1_FLAG_CLEAR <= next_ext1_clr;
      TIMER0_FLAG_CLEAR <= next_tmr0_clr;
      TIMER1_FLAG_CLEAR <= next_tmr1_clr;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  // The offer rests on the pending bits of the edge that launched it, so a
  // legal withdrawal in the offer's last cycle does not trip this check.
  a_offer_real_src: assert property (INT_REQ |-> chosen_idx < 3'h6 &&
                                     ($past(pending) & (6'h01 << chosen_idx)) != 6'h00)
    else $error("offered source is out of range or was not pending");

  a_level_encode: assert property (pick_found |-> pick_level ==
                                   {priority_high_bits[pick_idx], priority_low_bits[pick_idx]})
    else $error("picked level does not match its priority bits");

  a_offer_above_top: assert property (INT_REQ |-> !stack_any || chosen_level > top_level)
    else $error("offer made at or below a level in service");

  a_top_blocks_all: assert property (in_service[3] && $past(in_service[3]) |-> !INT_REQ)
    else $error("request offered while a top level routine runs");

  a_push_records: assert property (push |=> in_service[$past(chosen_level)])
    else $error("vectored level not recorded in service");

  a_return_pops: assert property (INT_RETURN && !push && stack_any |=>
                                  $countones(in_service) == $countones($past(in_service)) - 1)
    else $error("return did not end exactly one routine");

  a_vector_map: assert property ($rose(INT_REQ) |->
                                 INT_VECTOR == `FIP_VEC_BASE + {2'b00, chosen_idx, 3'b000})
    else $error("vector does not match offered source");

  a_tie_lowest: assert property (pick_found && pick_idx != 3'h0 |->
                                 !(pending[0] && {priority_high_bits[0], priority_low_bits[0]}
                                   == pick_level))
    else $error("same level tie not resolved toward external 0");

  a_ext0_edge_clr: assert property (push && chosen_idx == `FIP_SRC_EXT0 |=>
                                    EXT0_FLAG_CLEAR == $past(EXT0_EDGE_MODE))
    else $error("external 0 flag clear disagrees with trigger mode");

  a_timer_clr: assert property (push && chosen_idx == `FIP_SRC_TIMER1 |=>
                                TIMER1_FLAG_CLEAR && !TIMER0_FLAG_CLEAR)
    else $error("timer 1 flag not cleared on vectoring");

  a_no_stray_clr: assert property (EXT1_FLAG_CLEAR || TIMER0_FLAG_CLEAR |-> $past(push))
    else $error("flag clear pulse without vectoring");

  a_ie_write: assert property (SFR_WR && SFR_ADDR == `FIP_ADDR_IRQ_ENABLE |=>
                               interrupt_enable == ($past(SFR_WDATA) & 8'hBF))
    else $error("enable register write not stored with bit 6 clear");

  a_iph_write: assert property (SFR_WR && SFR_ADDR == `FIP_ADDR_PRIO_HIGH |=>
                                priority_high_bits == ($past(SFR_WDATA) & 8'h3F))
    else $error("high priority register write not stored");

  a_ipl_readback: assert property ($past(SFR_ADDR) == `FIP_ADDR_PRIO_LOW |->
                                   SFR_RDATA == $past(priority_low_bits) && SFR_RDATA[7:6] == 2'b00)
    else $error("low priority register read back wrong");

  a_gate_blocks: assert property (!global_irq_gate |=> !INT_REQ)
    else $error("request offered while global gate is clear");

  c_preempt: cover property (push && stack_any);
  c_three_deep: cover property ($countones(in_service) == 3);
  c_withdraw: cover property (state == ST_OFFER && !INT_ACK && !pending[chosen_idx]);
  c_edge_clear: cover property (EXT0_FLAG_CLEAR);

endmodule

/* File: bench/fip_core_model.sv */
// Purpose: Behavioural processor core that takes offered vectors and returns.
// Assumes: Offers and strobes are sampled on the rising clock edge.
// Notes:   Ack delay alternates prompt and slow; returns come on request or by themselves.
module fip_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic int_req,
  input wire logic auto_ret,
  input wire logic ret_req,
  output logic int_ack,
  output logic int_return
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_cnt;
  logic slow;
  logic [2:0] ret_cnt;

  // One ack per offer; the edge after an ack is skipped so one offer is never taken twice.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ack <= 1'b0;
      int_return <= 1'b0;
      wait_cnt <= 2'd0;
      slow <= 1'b0;
      ret_cnt <= 3'd0;
    end else begin
      int_ack <= 1'b0;
      int_return <= ret_req | (ret_cnt == 3'd1);
      if (ret_cnt != 3'd0) begin
        ret_cnt <= ret_cnt - 3'd1;
      end
      if (int_req && !int_ack) begin
        if (wait_cnt == (slow ? 2'd2 : 2'd0)) begin
          int_ack <= 1'b1;
          wait_cnt <= 2'd0;
          slow <= !slow;
          ret_cnt <= auto_ret ? 3'd4 : 3'd0;
        end else begin
          wait_cnt <= wait_cnt + 2'd1;
        end
      end else begin
        wait_cnt <= 2'd0;
      end
    end
  end
endmodule

/* File: bench/fip_intc_tb.sv */
// Purpose: Self-checking bench for the nested priority logic.
// Assumes: Peripherals drop a flag on its clear pulse; software clears the rest.
// Notes:   Expected vectors are queued by the driver and checked when the core takes them.
`include "fip_defs.svh"
module fip_intc_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int fmap [4] = '{0, 2, 1, 3};
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic SFR_WR = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  logic [7:0] SFR_RDATA;
  logic [7:0] flag = 8'h00;
  logic [1:0] edge_mode = 2'b11;
  logic INT_ACK;
  logic INT_RETURN;
  logic INT_REQ;
  logic [7:0] INT_VECTOR;
  logic [3:0] clr;
  logic auto_ret = 1'b1;
  logic ret_req = 1'b0;
  logic [7:0] sw_vec = 8'h00;
  logic [31:0] rng = 32'h51F6BE8E;
  logic [31:0] r;
  logic [7:0] exp_q [$];
  int n_clr [4] = '{default: 0};
  int errors = 0;
  int n_compared = 0;

  always #12.5 CLK_SYS = ~CLK_SYS;

  fip_intc fip_intc_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .EXT0_REQUEST_FLAG(flag[0]), .EXT1_REQUEST_FLAG(flag[2]),
    .EXT0_EDGE_MODE(edge_mode[0]), .EXT1_EDGE_MODE(edge_mode[1]),
    .TIMER0_OVERFLOW_FLAG(flag[1]), .TIMER1_OVERFLOW_FLAG(flag[3]),
    .TIMER2_OVERFLOW_FLAG(flag[5]), .TIMER2_EXTERNAL_FLAG(flag[7]),
    .RX_DONE_FLAG(flag[4]), .TX_DONE_FLAG(flag[6]), .INT_ACK(INT_ACK),
    .INT_RETURN(INT_RETURN), .INT_REQ(INT_REQ), .INT_VECTOR(INT_VECTOR),
    .EXT0_FLAG_CLEAR(clr[0]), .EXT1_FLAG_CLEAR(clr[1]),
    .TIMER0_FLAG_CLEAR(clr[2]), .TIMER1_FLAG_CLEAR(clr[3]));

  fip_core_model fip_core_model_i (.clk(CLK_SYS), .rst_n(RST_N), .int_req(INT_REQ),
    .auto_ret(auto_ret), .ret_req(ret_req), .int_ack(INT_ACK), .int_return(INT_RETURN));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic results();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(logic [7:0] got, logic [7:0] exp, string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(negedge CLK_SYS);
  endtask

  // Writes hold the strobe for exactly one rising edge, then let one edge pass
  // with it low so that a following write never lowers and raises it at once.
  task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    tick(1);
    SFR_WR = 1'b0;
    tick(1);
  endtask

  // Read data is registered, so it is checked one edge after the address.
  task automatic sfr_rd(logic [7:0] a, logic [7:0] e);
    SFR_ADDR = a;
    tick(1);
    chk(SFR_RDATA, e, "register read");
  endtask

  task automatic ret();
    ret_req = 1'b1;
    tick(1);
    ret_req = 1'b0;
    tick(1);
  endtask

  // Bounded wait until every queued vector is taken and the offer has fallen.
  task automatic wait_q();
    int i;
    for (i = 0; i < 300; i++) begin
      if (exp_q.size() == 0 && INT_REQ === 1'b0 && INT_ACK === 1'b0) break;
      tick(1);
    end
    if (i == 300) begin
      errors++;
      $display("MISMATCH %0t wait for vectors ran out", $time);
      results();
    end
    tick(8);
  endtask

  // Monitor: every vector the core takes is matched against the oldest note.
  always @(posedge CLK_SYS) begin
    if (RST_N && INT_REQ === 1'b1 && INT_ACK === 1'b1) begin
      if (exp_q.size() == 0) chk(INT_VECTOR, 8'hEE, "unexpected vector");
      else chk(INT_VECTOR, exp_q.pop_front(), "vector");
      sw_vec <= INT_VECTOR;
    end
  end

  // Peripherals obey clear pulses; software clears flags the hardware leaves set.
  always @(negedge CLK_SYS) begin
    for (int k = 0; k < 4; k++) begin
      if (clr[k] === 1'b1) begin
        flag[fmap[k]] = 1'b0;
        n_clr[k]++;
      end
    end
    case (sw_vec)
      8'h03: if (!edge_mode[0]) flag = flag & 8'hFE;
      8'h13: if (!edge_mode[1]) flag = flag & 8'hFB;
      8'h23: flag = flag & 8'hAF;
      8'h2B: flag = flag & 8'h5F;
      default: ;
    endcase
    sw_vec = 8'h00;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(10);
    RST_N = 1'b1;
    sfr_rd(`FIP_ADDR_IRQ_ENABLE, 8'h00);
    sfr_rd(`FIP_ADDR_PRIO_HIGH, 8'h00);
    sfr_rd(`FIP_ADDR_PRIO_LOW, 8'h00);
    sfr_wr(`FIP_ADDR_IRQ_ENABLE, 8'hFF);
    sfr_rd(`FIP_ADDR_IRQ_ENABLE, 8'hBF);
    sfr_wr(`FIP_ADDR_PRIO_HIGH, 8'hFF);
    sfr_rd(`FIP_ADDR_PRIO_HIGH, 8'h3F);
    sfr_wr(`FIP_ADDR_PRIO_LOW, 8'hFF);
    sfr_rd(`FIP_ADDR_PRIO_LOW, 8'h3F);
    sfr_wr(8'h5A, 8'hFF);
    sfr_rd(8'h5A, 8'h00);
    // Gate closed with every source raised, then opened: polling order at one level.
    sfr_wr(`FIP_ADDR_IRQ_ENABLE, 8'h3F);
    flag = 8'hFF;
    tick(6);
    chk({7'h00, INT_REQ}, 8'h00, "gate closed");
    exp_q = '{8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23, 8'h2B};
    sfr_wr(`FIP_ADDR_IRQ_ENABLE, 8'hFF);
    wait_q();
    for (int k = 0; k < 4; k++) chk(n_clr[k][7:0], 8'h01, "clear pulses");
    // Level-triggered externals get no clear pulse.
    edge_mode = 2'b00;
    n_clr = '{default: 0};
    exp_q = '{8'h03, 8'h13};
    flag = 8'h05;
    wait_q();
    chk(n_clr[0][7:0] + n_clr[1][7:0], 8'h00, "level clears");
    // Nesting: ext0 L0, timer0 L1, ext1 L0, timer1 L3.
    edge_mode = 2'b11;
    auto_ret = 1'b0;
    sfr_wr(`FIP_ADDR_PRIO_HIGH, 8'h08);
    sfr_wr(`FIP_ADDR_PRIO_LOW, 8'h0A);
    // A timer 2 offer whose flag falls before the core takes it is withdrawn.
    flag[5] = 1'b1;
    tick(1);
    chk({7'h00, INT_REQ}, 8'h01, "offer raised");
    chk(INT_VECTOR, 8'h2B, "withdrawn vector");
    flag[5] = 1'b0;
    tick(2);
    chk({7'h00, INT_REQ}, 8'h00, "offer withdrawn");
    exp_q.push_back(8'h03);
    flag[0] = 1'b1;
    wait_q();
    exp_q.push_back(8'h0B);
    flag[1] = 1'b1;
    wait_q();
    flag[2] = 1'b1;
    tick(6);
    chk({7'h00, INT_REQ}, 8'h00, "equal level waits");
    exp_q.push_back(8'h1B);
    flag[3] = 1'b1;
    wait_q();
    ret();
    ret();
    tick(4);
    chk({7'h00, INT_REQ}, 8'h00, "level 0 still busy");
    exp_q.push_back(8'h13);
    ret();
    wait_q();
    ret();
    auto_ret = 1'b1;
    // Random levels for timer0 and serial raised together.
    repeat (8) begin
      r = rnd();
      sfr_wr(`FIP_ADDR_PRIO_HIGH, {3'b000, r[3], 2'b00, r[1], 1'b0});
      sfr_wr(`FIP_ADDR_PRIO_LOW, {3'b000, r[2], 2'b00, r[0], 1'b0});
      if (r[3:2] > r[1:0]) exp_q = '{8'h23, 8'h0B};
      else exp_q = '{8'h0B, 8'h23};
      flag[1] = 1'b1;
      flag[r[4] ? 6 : 4] = 1'b1;
      wait_q();
    end
    results();
  end
endmodule
